// *** charger_register_bank.sv ***
// two-wire serial slave with measurement setup, throttle and status registers
`timescale 1ns/100ps
module charger_register_bank
  import charger_regs_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR = DEVICE_ADDR_DEFAULT,
  parameter int CONV_SET_CYCLES = CONV_SET_TIME_US * CLK_FREQ_MHZ,
  parameter int REPEAT_PERIOD_CYCLES = REPEAT_PERIOD_MS * US_PER_MS * CLK_FREQ_MHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // serial host bus, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // charger condition inputs
  input wire logic charge_ok_indication,
  input wire logic optimizer_complete_flag,
  input wire logic voltage_regulation_active,
  input wire logic input_current_regulation_active,
  input wire logic fast_charge_active,
  input wire logic precharge_active,
  input wire logic reverse_boost_active,
  // fault events: input ov, battery oc, input oc, latch-off, boost ov, boost uc
  input wire logic [FAULT_COUNT-1:0] fault_event,
  input wire logic system_overvoltage_event,
  // power mode
  input wire logic battery_only,
  input wire logic low_power_request,
  // processor-hot pin, open drain
  output logic processor_hot_out,
  output logic processor_hot_oe,
  // measurement front end
  output logic [2:0] channel_sel,
  output logic sample_strobe,
  output logic results_update,
  output logic input_range_select,
  output logic low_power_active,
  output logic converter_enable
);

  localparam int SLOT_CYCLES = (CONV_SET_CYCLES / CHANNEL_COUNT < 1) ? 1 :
    CONV_SET_CYCLES / CHANNEL_COUNT;

  typedef enum logic [2:0] {
    BUS_IDLE, BUS_ADDR, BUS_ACK_ADDR, BUS_RX, BUS_ACK_RX, BUS_TX, BUS_ACK_TX
  } bus_state_t;

  typedef struct packed {
    logic scl_q;
    logic sda_q;
    bus_state_t st;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic ptr_loaded;
    logic master_ack;
    logic sda_drive;
    logic [FAULT_COUNT-1:0] snap;
    logic snap_valid;
    logic [15:0] setup;
    logic [7:0] throttle;
    logic [LIVE_COUNT+1:0] live;
    logic sysovp;
    logic charge_ok_q;
    logic hot;
  } bank_t;

  bank_t s_r;
  bank_t s_nxt;

  logic [FAULT_COUNT-1:0] fault_flags;
  logic [FAULT_COUNT-1:0] fault_clear;
  logic [15:0] status_word;
  logic adc_run;
  logic set_done;
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  logic wr_en;
  logic [7:0] wr_data;
  logic sysovp_wr_clear;

  // status word: live bits registered, faults from the latch bank
  always_comb begin
    status_word = STATUS_RESET;
    status_word[ST_PRESENT_BIT] = s_r.live[LIVE_COUNT+1];
    status_word[ST_OPT_DONE_BIT] = s_r.live[LIVE_COUNT];
    status_word[ST_VREG_BIT] = s_r.live[LIVE_COUNT-1];
    status_word[ST_VREG_BIT-1:ST_OTG_BIT] = s_r.live[LIVE_COUNT-2:0];
    status_word[ST_IN_OV_BIT:ST_IN_OC_BIT] = fault_flags[FAULT_COUNT-1:3];
    status_word[ST_SYSOVP_BIT] = s_r.sysovp;
    status_word[ST_LATCHOFF_BIT:ST_OTG_UCP_BIT] = fault_flags[2:0];
  end

  function automatic logic [7:0] read_byte(input logic [7:0] addr, input logic [15:0] stat,
                                           input logic [15:0] setup, input logic [7:0] thr);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      STATUS_LO_ADDR: v = stat[7:0];
      STATUS_HI_ADDR: v = stat[15:8];
      THROTTLE_LO_ADDR: v = thr;
      SETUP_LO_ADDR: v = setup[7:0];
      SETUP_HI_ADDR: v = setup[15:8];
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_byte

  assign start_cond = s_r.scl_q & scl_in & s_r.sda_q & ~sda_in;
  assign stop_cond = s_r.scl_q & scl_in & ~s_r.sda_q & sda_in;
  assign scl_rise = ~s_r.scl_q & scl_in;
  assign scl_fall = s_r.scl_q & ~scl_in;

  always_comb begin
    s_nxt = s_r;
    wr_en = 1'b0;
    wr_data = s_r.shift;
    fault_clear = '0;
    sysovp_wr_clear = 1'b0;
    s_nxt.scl_q = scl_in;
    s_nxt.sda_q = sda_in;

    // serial protocol
    case (s_r.st)
      BUS_IDLE: begin
        s_nxt.sda_drive = 1'b0;
      end
      BUS_ADDR, BUS_RX: begin
        if (scl_rise) begin
          s_nxt.shift = {s_r.shift[6:0], sda_in};
          s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
        end else if (scl_fall && s_r.bit_cnt == BYTE_BITS) begin
          s_nxt.bit_cnt = '0;
          if (s_r.st == BUS_ADDR) begin
            if (s_r.shift[7:1] == DEVICE_ADDR) begin
              s_nxt.sda_drive = 1'b1;
              s_nxt.st = BUS_ACK_ADDR;
            end else begin
              s_nxt.st = BUS_IDLE;
            end
          end else begin
            s_nxt.sda_drive = 1'b1;
            s_nxt.st = BUS_ACK_RX;
            if (!s_r.ptr_loaded) begin
              s_nxt.ptr = s_r.shift;
              s_nxt.ptr_loaded = 1'b1;
            end else begin
              wr_en = 1'b1;
              s_nxt.ptr = s_r.ptr + 8'h01;
            end
          end
        end
      end
      BUS_ACK_ADDR: begin
        if (scl_fall) begin
          if (s_r.shift[0]) begin
            s_nxt.shift = read_byte(s_r.ptr, status_word, s_r.setup, s_r.throttle);
            s_nxt.snap = fault_flags;
            s_nxt.snap_valid = (s_r.ptr == STATUS_LO_ADDR);
            s_nxt.sda_drive = ~s_nxt.shift[7];
            s_nxt.st = BUS_TX;
          end else begin
            s_nxt.sda_drive = 1'b0;
            s_nxt.ptr_loaded = 1'b0;
            s_nxt.st = BUS_RX;
          end
        end
      end
      BUS_ACK_RX: begin
        if (scl_fall) begin
          s_nxt.sda_drive = 1'b0;
          s_nxt.st = BUS_RX;
        end
      end
      BUS_TX: begin
        if (scl_rise) begin
          s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
        end else if (scl_fall) begin
          if (s_r.bit_cnt == BYTE_BITS) begin
            s_nxt.bit_cnt = '0;
            s_nxt.sda_drive = 1'b0;
            s_nxt.st = BUS_ACK_TX;
          end else begin
            s_nxt.shift = {s_r.shift[6:0], 1'b0};
            s_nxt.sda_drive = ~s_r.shift[6];
          end
        end
      end
      BUS_ACK_TX: begin
        if (scl_rise) begin
          s_nxt.master_ack = ~sda_in;
          s_nxt.ptr = s_r.ptr + 8'h01;
          // only the fault bits that went out as ones are cleared
          if (s_r.snap_valid) begin
            fault_clear = s_r.snap;
          end
          s_nxt.snap_valid = 1'b0;
        end else if (scl_fall) begin
          if (s_r.master_ack) begin
            s_nxt.shift = read_byte(s_r.ptr, status_word, s_r.setup, s_r.throttle);
            s_nxt.snap = fault_flags;
            s_nxt.snap_valid = (s_r.ptr == STATUS_LO_ADDR);
            s_nxt.sda_drive = ~s_nxt.shift[7];
            s_nxt.st = BUS_TX;
          end else begin
            s_nxt.st = BUS_IDLE;
          end
        end
      end
      default: begin
        s_nxt.st = BUS_IDLE;
      end
    endcase

    if (stop_cond) begin
      s_nxt.st = BUS_IDLE;
      s_nxt.sda_drive = 1'b0;
    end else if (start_cond) begin
      s_nxt.st = BUS_ADDR;
      s_nxt.bit_cnt = '0;
      s_nxt.sda_drive = 1'b0;
    end

    // register writes; the status word ignores all but the bit 4 clear
    if (wr_en) begin
      case (s_r.ptr)
        SETUP_LO_ADDR: s_nxt.setup[7:0] = wr_data;
        SETUP_HI_ADDR: s_nxt.setup[15:8] = wr_data;
        THROTTLE_LO_ADDR: s_nxt.throttle = wr_data;
        STATUS_LO_ADDR: sysovp_wr_clear = ~wr_data[ST_SYSOVP_BIT];
        default: ;
      endcase
    end

    // a one-shot set retires its start request; a same-cycle write wins
    if (set_done && !s_r.setup[SETUP_REPEAT_BIT]
        && !(wr_en && s_r.ptr == SETUP_HI_ADDR)) begin
      s_nxt.setup[SETUP_START_BIT] = 1'b0;
    end

    // live status follows present conditions
    s_nxt.live = {charge_ok_indication, optimizer_complete_flag, voltage_regulation_active,
                  input_current_regulation_active, fast_charge_active, precharge_active,
                  reverse_boost_active};

    // overvoltage latch: clear needs the condition gone; set wins
    if (system_overvoltage_event) begin
      s_nxt.sysovp = 1'b1;
    end else if (sysovp_wr_clear || !charge_ok_indication) begin
      s_nxt.sysovp = 1'b0;
    end

    // throttle pin held low from adapter removal until it returns
    s_nxt.charge_ok_q = charge_ok_indication;
    if (!s_r.throttle[THROTTLE_ADAPTER_BIT] || charge_ok_indication) begin
      s_nxt.hot = 1'b0;
    end else if (s_r.charge_ok_q) begin
      s_nxt.hot = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.scl_q <= 1'b1;
      s_r.sda_q <= 1'b1;
      s_r.st <= BUS_IDLE;
      s_r.setup <= SETUP_RESET;
      s_r.throttle <= THROTTLE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // leaving low power on battery when the converter is asked to run
  assign low_power_active = low_power_request
    & ~(s_r.setup[SETUP_START_BIT] & battery_only);
  assign adc_run = s_r.setup[SETUP_START_BIT] & ~low_power_active;

  fault_latch_bank u_faults (
    .clk(clk),
    .reset(reset),
    .fault_event(fault_event),
    .fault_clear(fault_clear),
    .fault_flags(fault_flags)
  );

  // busy unused: the start bit already tells whether a set may run
  conversion_sequencer #(
    .SLOT_CYCLES(SLOT_CYCLES),
    .PERIOD_CYCLES(REPEAT_PERIOD_CYCLES)
  ) u_seq (
    .clk(clk),
    .reset(reset),
    .run(adc_run),
    .repeat_mode(s_r.setup[SETUP_REPEAT_BIT]),
    .channel_enables(s_r.setup[CHANNEL_COUNT-1:0]),
    .channel_sel(channel_sel),
    .sample_strobe(sample_strobe),
    .set_done(set_done),
    .busy()
  );

  assign results_update = set_done;
  assign input_range_select = s_r.setup[SETUP_RANGE_BIT];
  assign converter_enable = ~s_r.sysovp;
  assign sda_out = 1'b0;
  assign sda_oe = s_r.sda_drive;
  assign processor_hot_out = 1'b0;
  assign processor_hot_oe = s_r.hot;

endmodule : charger_register_bank

// *** charger_register_bank_props.sv ***
// assertions on the ports of the charger register bank
`timescale 1ns/100ps
module charger_register_bank_props #(
  parameter int CONV_SET_CYCLES = 500000,
  parameter int REPEAT_PERIOD_CYCLES = 50000000
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bus and pins
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic processor_hot_out,
  input wire logic processor_hot_oe,
  // conditions
  input wire logic charge_ok_indication,
  input wire logic system_overvoltage_event,
  input wire logic battery_only,
  input wire logic low_power_request,
  // front end
  input wire logic [2:0] channel_sel,
  input wire logic sample_strobe,
  input wire logic results_update,
  input wire logic input_range_select,
  input wire logic low_power_active,
  input wire logic converter_enable
);
  localparam int SLOT = CONV_SET_CYCLES / 8;
  logic [31:0] gap_r;
  logic in_set_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // an aborted set must not be judged against the next one
  always_ff @(posedge clk) begin
    gap_r <= (reset || sample_strobe) ? 32'h1 : gap_r + 32'h1;
    in_set_r <= !(reset || results_update || low_power_active || !converter_enable)
      && (in_set_r || sample_strobe);
  end
  property p_rst_vals; $past(reset) |-> input_range_select && converter_enable
    && !sda_oe && !processor_hot_oe; endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad values after reset");
  property p_pins_od; !sda_out && !processor_hot_out; endproperty
  a_pins_od: assert property (p_pins_od) else $error("open drain pin driven high");
  property p_hot_cause; $rose(processor_hot_oe) |-> !$past(charge_ok_indication); endproperty
  a_hot_cause: assert property (p_hot_cause) else $error("throttle without removal");
  property p_hot_drop; $rose(charge_ok_indication) |-> ##[1:3] !processor_hot_oe; endproperty
  a_hot_drop: assert property (p_hot_drop) else $error("throttle held after return");
  property p_lp_hold; low_power_active && $past(low_power_active)
    |-> !sample_strobe && !results_update; endproperty
  a_lp_hold: assert property (p_lp_hold) else $error("conversion in low power");
  property p_lp_exit; low_power_request && !low_power_active |-> battery_only; endproperty
  a_lp_exit: assert property (p_lp_exit) else $error("low power left wrongly");
  property p_update_last; results_update |-> channel_sel == 3'h7; endproperty
  a_update_last: assert property (p_update_last) else $error("update not after last");
  property p_slot; sample_strobe && in_set_r |-> (gap_r % SLOT) == 0; endproperty
  a_slot: assert property (p_slot) else $error("strobe off slot grid");
  property p_ovp; system_overvoltage_event |-> ##[1:2] !converter_enable; endproperty
  a_ovp: assert property (p_ovp) else $error("converter on in overvoltage");
  property p_ack_low; $rose(sda_oe) |-> !scl_in && !$past(scl_in); endproperty
  a_ack_low: assert property (p_ack_low) else $error("data driven in clock high");
endmodule : charger_register_bank_props

bind charger_register_bank charger_register_bank_props #(
  .CONV_SET_CYCLES(CONV_SET_CYCLES),
  .REPEAT_PERIOD_CYCLES(REPEAT_PERIOD_CYCLES)
) u_props (.clk, .reset, .scl_in, .sda_out, .sda_oe, .processor_hot_out,
  .processor_hot_oe, .charge_ok_indication, .system_overvoltage_event, .battery_only,
  .low_power_request, .channel_sel, .sample_strobe, .results_update,
  .input_range_select, .low_power_active, .converter_enable);

// *** charger_register_bank_tb.sv ***
// self-checking bench for the charger register bank
`timescale 1ns/100ps
module charger_register_bank_tb
  import charger_regs_pkg::*;
;
  logic clk, reset, ok, ovp, bat, lpr, scl, hsda;
  logic [5:0] live, fev;
  logic sda_out, sda_oe, hot_out, hot_oe, strb, upd, range_o, lp_o, conv_o;
  logic [2:0] ch;
  logic [11:0] seq;
  int n_strb, n_upd, miscompares, n_checks;
  wire sda_line = hsda & (sda_oe ? sda_out : 1'b1);

  charger_register_bank #(.CONV_SET_CYCLES(80), .REPEAT_PERIOD_CYCLES(400)) u_dut (
    .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .charge_ok_indication(ok),
    .optimizer_complete_flag(live[5]), .voltage_regulation_active(live[4]),
    .input_current_regulation_active(live[3]), .fast_charge_active(live[2]),
    .precharge_active(live[1]), .reverse_boost_active(live[0]),
    .fault_event(fev), .system_overvoltage_event(ovp), .battery_only(bat),
    .low_power_request(lpr), .processor_hot_out(hot_out), .processor_hot_oe(hot_oe),
    .channel_sel(ch), .sample_strobe(strb), .results_update(upd),
    .input_range_select(range_o), .low_power_active(lp_o), .converter_enable(conv_o));
  i2c_host_model u_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(hsda));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (strb === 1'b1) begin
      n_strb++;
      seq = {seq[8:0], ch};
    end
    if (upd === 1'b1) n_upd++;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k1, k2, k3;
    u_host.start();
    u_host.wbyte({DEVICE_ADDR_DEFAULT, 1'b0}, k1);
    u_host.wbyte(a, k2);
    u_host.wbyte(d, k3);
    u_host.stop();
    chk("write ack", 16'h0007, {13'h0, k1, k2, k3});
  endtask : wr
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic k;
    logic [7:0] d;
    u_host.start();
    u_host.wbyte({DEVICE_ADDR_DEFAULT, 1'b0}, k);
    u_host.wbyte(a, k);
    u_host.start();
    u_host.wbyte({DEVICE_ADDR_DEFAULT, 1'b1}, k);
    u_host.rbyte(d);
    u_host.stop();
    chk(what, {8'h00, exp}, {8'h00, d});
  endtask : rchk
  task automatic report_and_stop();
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic t_reset_map();
    rchk("setup lo", 8'h3A, 8'h00);
    rchk("setup hi", 8'h3B, 8'h20);
    rchk("status lo", 8'h20, 8'h00);
    rchk("status hi", 8'h21, 8'h00);
    rchk("unmapped", 8'h39, 8'h00);
    chk("range", 16'h0001, {15'h0, range_o});
  endtask : t_reset_map
  task automatic t_setup_rw();
    wr(8'h3A, 8'hA5);
    wr(8'h3B, 8'h1F);
    rchk("setup lo", 8'h3A, 8'hA5);
    rchk("setup hi", 8'h3B, 8'h1F);
    chk("range", 16'h0000, {15'h0, range_o});
  endtask : t_setup_rw
  task automatic t_status();
    ok = 1'b1;
    live = 6'h3F;
    step(2);
    rchk("status hi", 8'h21, 8'hDF);
    wr(8'h21, 8'h00);
    rchk("status ro", 8'h21, 8'hDF);
    ok = 1'b0;
    live = 6'h2A;
    step(2);
    rchk("status live", 8'h21, 8'h4A);
    live = 6'h00;
  endtask : t_status
  task automatic t_faults();
    fev = 6'h3F;
    step(1);
    fev = 6'h00;
    rchk("faults", 8'h20, 8'hE7);
    rchk("faults cleared", 8'h20, 8'h00);
  endtask : t_faults
  task automatic t_ovp();
    ok = 1'b1;
    ovp = 1'b1;
    step(3);
    chk("conv off", 16'h0000, {15'h0, conv_o});
    ovp = 1'b0;
    rchk("ovp", 8'h20, 8'h10);
    rchk("ovp kept", 8'h20, 8'h10);
    wr(8'h20, 8'h00);
    step(2);
    chk("conv on", 16'h0001, {15'h0, conv_o});
    rchk("ovp clear", 8'h20, 8'h00);
  endtask : t_ovp
  task automatic t_oneshot();
    wr(8'h3A, 8'h85);
    n_strb = 0;
    n_upd = 0;
    seq = 12'h000;
    wr(8'h3B, 8'h40);
    step(200);
    chk("updates", 16'h0001, 16'(n_upd));
    chk("strobes", 16'h0003, 16'(n_strb));
    chk("order", 16'h0017, {7'h0, seq[8:0]});
    step(400);
    chk("no repeat", 16'h0001, 16'(n_upd));
    rchk("start clear", 8'h3B, 8'h00);
  endtask : t_oneshot
  task automatic t_repeat();
    n_upd = 0;
    wr(8'h3B, 8'hC0);
    step(1000);
    chk("periodic", 16'h0003, 16'(n_upd));
    wr(8'h3B, 8'h20);
    step(20);
    n_upd = 0;
    step(500);
    chk("stopped", 16'h0000, 16'(n_upd));
    chk("range", 16'h0001, {15'h0, range_o});
  endtask : t_repeat
  task automatic t_lowpower();
    wr(8'h3A, 8'h01);
    lpr = 1'b1;
    step(2);
    chk("low power", 16'h0001, {15'h0, lp_o});
    n_strb = 0;
    n_upd = 0;
    wr(8'h3B, 8'h40);
    step(200);
    chk("held off", 16'h0000, 16'(n_strb));
    bat = 1'b1;
    step(1);
    chk("left low power", 16'h0000, {15'h0, lp_o});
    step(200);
    chk("ran", 16'h0001, 16'(n_upd));
    lpr = 1'b0;
    bat = 1'b0;
  endtask : t_lowpower
  task automatic t_throttle();
    ok = 1'b1;
    wr(8'h38, 8'h01);
    ok = 1'b0;
    step(4);
    chk("hot low", 16'h0001, {15'h0, hot_oe});
    ok = 1'b1;
    step(4);
    chk("hot freed", 16'h0000, {15'h0, hot_oe});
    wr(8'h38, 8'h00);
    ok = 1'b0;
    step(4);
    chk("hot off", 16'h0000, {15'h0, hot_oe});
    ok = 1'b1;
  endtask : t_throttle

  initial begin
    reset = 1'b1;
    ok = 1'b0;
    live = 6'h00;
    fev = 6'h00;
    ovp = 1'b0;
    bat = 1'b0;
    lpr = 1'b0;
    step(8);
    reset = 1'b0;
    step(2);
    t_reset_map();
    t_setup_rw();
    t_status();
    t_faults();
    t_ovp();
    t_oneshot();
    t_repeat();
    t_lowpower();
    t_throttle();
    report_and_stop();
  end
  // about three times the expected run
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
endmodule : charger_register_bank_tb

// *** charger_regs_pkg.sv ***
// shared constants for the charger register bank: map, fields, resets, timing
package charger_regs_pkg;

  // clock and timing, each time in its own unit
  localparam int CLK_FREQ_MHZ = 50;
  localparam int CONV_SET_TIME_US = 10000;
  localparam int REPEAT_PERIOD_MS = 1000;
  localparam int US_PER_MS = 1000;
  localparam int CHANNEL_COUNT = 8;

  // bus address of the device; value is arbitrary
  localparam logic [6:0] DEVICE_ADDR_DEFAULT = 7'h5A;

  // register byte addresses
  localparam logic [7:0] STATUS_LO_ADDR = 8'h20;
  localparam logic [7:0] STATUS_HI_ADDR = 8'h21;
  localparam logic [7:0] THROTTLE_LO_ADDR = 8'h38;
  localparam logic [7:0] SETUP_LO_ADDR = 8'h3A;
  localparam logic [7:0] SETUP_HI_ADDR = 8'h3B;

  // reset values
  localparam logic [15:0] SETUP_RESET = 16'h2000;
  localparam logic [7:0] THROTTLE_RESET = 8'h20;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // measurement setup and throttle fields
  localparam int SETUP_REPEAT_BIT = 15;
  localparam int SETUP_START_BIT = 14;
  localparam int SETUP_RANGE_BIT = 13;
  localparam int THROTTLE_ADAPTER_BIT = 0;

  // status word fields
  localparam int ST_PRESENT_BIT = 15;
  localparam int ST_OPT_DONE_BIT = 14;
  localparam int ST_VREG_BIT = 12;
  localparam int ST_OTG_BIT = 8;
  localparam int ST_IN_OV_BIT = 7;
  localparam int ST_IN_OC_BIT = 5;
  localparam int ST_SYSOVP_BIT = 4;
  localparam int ST_LATCHOFF_BIT = 2;
  localparam int ST_OTG_UCP_BIT = 0;
  localparam int LIVE_COUNT = 5;
  localparam int FAULT_COUNT = 6;

  // serial bus framing
  localparam logic [3:0] BYTE_BITS = 4'h8;

endpackage : charger_regs_pkg

// *** conversion_sequencer.sv ***
// steps the measurement channels in fixed order, one-shot or periodic
`timescale 1ns/100ps
module conversion_sequencer
  import charger_regs_pkg::*;
#(
  parameter int SLOT_CYCLES = 62500,
  parameter int PERIOD_CYCLES = 50000000
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic run,
  input wire logic repeat_mode,
  input wire logic [CHANNEL_COUNT-1:0] channel_enables,
  // to the analogue front end
  output logic [2:0] channel_sel,
  output logic sample_strobe,
  output logic set_done,
  output logic busy
);

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONV, SEQ_WAIT} seq_state_t;

  typedef struct packed {
    seq_state_t st;
    logic [2:0] ch;
    logic [31:0] slot_cnt;
    logic [31:0] period_cnt;
    logic [2:0] shown;
    logic strobe;
    logic done;
  } seq_t;

  seq_t s_r;
  seq_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.strobe = 1'b0;
    s_nxt.done = 1'b0;
    // shown channel lags one clock so a strobe carries its own channel
    s_nxt.shown = s_r.ch;
    case (s_r.st)
      SEQ_IDLE: begin
        if (run) begin
          s_nxt.st = SEQ_CONV;
          s_nxt.ch = '0;
          s_nxt.slot_cnt = '0;
          s_nxt.period_cnt = '0;
        end
      end
      SEQ_CONV: begin
        s_nxt.period_cnt = s_r.period_cnt + 32'h1;
        s_nxt.slot_cnt = s_r.slot_cnt + 32'h1;
        if (s_r.slot_cnt == 32'(SLOT_CYCLES - 1)) begin
          s_nxt.slot_cnt = '0;
          // order: battery, system, charge, discharge, input, power, bus, comparator
          s_nxt.strobe = channel_enables[s_r.ch];
          if (s_r.ch == 3'(CHANNEL_COUNT - 1)) begin
            s_nxt.done = 1'b1;
            s_nxt.st = repeat_mode ? SEQ_WAIT : SEQ_IDLE;
          end else begin
            s_nxt.ch = s_r.ch + 3'h1;
          end
        end
      end
      SEQ_WAIT: begin
        s_nxt.period_cnt = s_r.period_cnt + 32'h1;
        if (s_r.period_cnt >= 32'(PERIOD_CYCLES - 1)) begin
          s_nxt.st = SEQ_CONV;
          s_nxt.ch = '0;
          s_nxt.period_cnt = '0;
        end
      end
      default: begin
        s_nxt.st = SEQ_IDLE;
      end
    endcase
    // dropping run aborts a set without an update
    if (!run) begin
      s_nxt.st = SEQ_IDLE;
      s_nxt.strobe = 1'b0;
      s_nxt.done = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign channel_sel = s_r.shown;
  assign sample_strobe = s_r.strobe;
  assign set_done = s_r.done;
  assign busy = (s_r.st != SEQ_IDLE);

endmodule : conversion_sequencer

// *** fault_latch_bank.sv ***
// sticky fault flags, set by hardware events, cleared per bit
`timescale 1ns/100ps
module fault_latch_bank
  import charger_regs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // events and clears
  input wire logic [FAULT_COUNT-1:0] fault_event,
  input wire logic [FAULT_COUNT-1:0] fault_clear,
  // latched flags
  output logic [FAULT_COUNT-1:0] fault_flags
);

  typedef struct packed {
    logic [FAULT_COUNT-1:0] flags;
  } bank_t;

  bank_t s_r;
  bank_t s_nxt;
  logic [FAULT_COUNT-1:0] flag_nxt;

  genvar i;
  generate
    for (i = 0; i < FAULT_COUNT; i++) begin : g_flag
      // set wins over a clear in the same cycle
      assign flag_nxt[i] = fault_event[i] | (s_r.flags[i] & ~fault_clear[i]);
    end
  endgenerate

  always_comb begin
    s_nxt = s_r;
    s_nxt.flags = flag_nxt;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fault_flags = s_r.flags;

endmodule : fault_latch_bank

// *** i2c_host_model.sv ***
// host controller model, master side of the two-wire bus
`timescale 1ns/100ps
module i2c_host_model (
  // clock
  input wire logic clk,
  // bus
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // four clocks a phase, above the device minimum of three
  task automatic ph();
    repeat (4) @(posedge clk);
    #1;
  endtask : ph
  task automatic start();
    sda = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda = 1'b0;
    ph();
    scl = 1'b0;
    ph();
  endtask : start
  task automatic stop();
    sda = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda = 1'b1;
    ph();
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    sda = b;
    ph();
    scl = 1'b1;
    ph();
    r = sda_line;
    scl = 1'b0;
    ph();
  endtask : bit_io
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte
  // always ends with a nack: one byte per read
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, r);
  endtask : rbyte
endmodule : i2c_host_model
